/* src/ulpi_clk_map.svh */
// Constants for the ULPI clock mode and pin control block.
`ifndef ULPI_CLK_MAP_SVH
`define ULPI_CLK_MAP_SVH

// Rising reference edges that switch the ULPI clock pin to output.
`define REF_EDGES_TO_OUTPUT 3'h4
// Reference clock frequencies chosen by the frequency-select pin, and the ULPI clock frequency, in kHz.
`define REF_FREQ_LOW_KHZ    32'h4B00
`define REF_FREQ_HIGH_KHZ   32'h6590
`define ULPI_FREQ_KHZ       32'hEA60
// Phase step per reference edge in sixteenths of a ULPI half period.
`define PHASE_UNIT          8'h10
`define PHASE_STEP_LOW \
    8'((2 * 16 * `ULPI_FREQ_KHZ + `REF_FREQ_LOW_KHZ / 2) / `REF_FREQ_LOW_KHZ)
`define PHASE_STEP_HIGH \
    8'((2 * 16 * `ULPI_FREQ_KHZ + `REF_FREQ_HIGH_KHZ / 2) / `REF_FREQ_HIGH_KHZ)
`define PHASE_LIMIT         8'hF0
// Reset values.
`define EDGE_COUNT_RST      3'h0
`define PHASE_RST           8'h00
`define DATA_RST            8'h00

`endif

/* src/ulpi_clk_pkg.sv */
// Types for the ULPI clock mode and pin control block.
`default_nettype none
package ulpi_clk_pkg;

    typedef enum logic {
        CLK_PIN_INPUT,
        CLK_PIN_OUTPUT
    } clk_mode_t;

    // Pin inputs after the two-stage synchronisers.
    typedef struct packed {
        logic ref_s1;
        logic ref_s2;
        logic ref_s3;
        logic cs_s1;
        logic cs_s2;
        logic rst_n_s1;
        logic rst_n_s2;
        logic fsel_s1;
        logic fsel_s2;
    } pin_sync_t;

    // Values driven onto the ULPI side pins.
    typedef struct packed {
        logic [7:0] data;
        logic       data_oe;
        logic       dir;
        logic       nxt;
        logic       bus_oe;
    } ulpi_drive_t;

    typedef struct packed {
        pin_sync_t   sync;
        clk_mode_t   mode;
        logic [2:0]  edge_count;
        logic [7:0]  phase;
        logic        ulpi_clk;
        logic        freq_high;
        logic        supply_en;
        ulpi_drive_t drive;
    } state_t;

endpackage
`default_nettype wire

/* src/ulpi_clock_mode_and_pin_control.sv */
// ULPI clock direction, chip select, reset and bus supply pin control.
`include "ulpi_clk_map.svh"
`default_nettype none

// Functional notes
// - Frequency-select low picks 19.2 MHz reference, high picks 26 MHz.
// - ULPI data lines transfer synchronously to the 60 MHz ULPI clock; the block registers them on clk_i instead.
// - ULPI clock pin is an input after power-up by default.
// - Four rising reference edges turn the ULPI clock pin into an output.
// - Chip select low powers down and tri-states all ULPI outputs.
// - Active-high push-pull output switches the external 5 V supply on.
// - Normal operation only while the active-low reset input is high.
module ulpi_clock_mode_and_pin_control (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       reference_clock_in_i,
    input  wire logic       freq_select_i,
    input  wire logic       chip_select_i,
    input  wire logic       active_low_reset_in_n_i,
    input  wire logic       bus_supply_req_i,
    input  wire logic [7:0] core_data_i,
    input  wire logic       core_data_oe_i,
    input  wire logic       core_dir_i,
    input  wire logic       core_nxt_i,
    output logic            ulpi_clk_o,
    output logic            ulpi_clk_oe_o,
    output logic [7:0]      ulpi_data_o,
    output logic            ulpi_data_oe_o,
    output logic            ulpi_dir_o,
    output logic            ulpi_dir_oe_o,
    output logic            ulpi_nxt_o,
    output logic            ulpi_nxt_oe_o,
    output logic            ref_freq_high_o,
    output logic            clk_out_mode_o,
    output logic            operating_o,
    output logic            bus_supply_enable_out_o
);

    ulpi_clk_pkg::state_t state_q;
    ulpi_clk_pkg::state_t state_d;

    logic       operate;
    logic       ref_rise;
    logic [7:0] step;
    logic [8:0] phase_sum;

    // Normal operation needs both chip select and the reset pin high.
    assign operate  = state_q.sync.cs_s2 && state_q.sync.rst_n_s2;
    assign ref_rise = state_q.sync.ref_s2 && !state_q.sync.ref_s3;
    assign step     = state_q.freq_high ? `PHASE_STEP_HIGH
                                        : `PHASE_STEP_LOW;

    always_comb begin
        state_d   = state_q;
        phase_sum = 9'h000;

        state_d.sync.ref_s1   = reference_clock_in_i;
        state_d.sync.ref_s2   = state_q.sync.ref_s1;
        state_d.sync.ref_s3   = state_q.sync.ref_s2;
        state_d.sync.cs_s1    = chip_select_i;
        state_d.sync.cs_s2    = state_q.sync.cs_s1;
        state_d.sync.rst_n_s1 = active_low_reset_in_n_i;
        state_d.sync.rst_n_s2 = state_q.sync.rst_n_s1;
        state_d.sync.fsel_s1  = freq_select_i;
        state_d.sync.fsel_s2  = state_q.sync.fsel_s1;

        state_d.freq_high = state_q.sync.fsel_s2;

        if (!operate) begin
            // Power-down or reset drops the clock pin back to input mode.
            state_d.mode       = ulpi_clk_pkg::CLK_PIN_INPUT;
            state_d.edge_count = `EDGE_COUNT_RST;
            state_d.phase      = `PHASE_RST;
            state_d.ulpi_clk   = 1'b0;
        end else begin
            case (state_q.mode)
                ulpi_clk_pkg::CLK_PIN_INPUT: begin
                    if (ref_rise) begin
                        state_d.edge_count = state_q.edge_count + 3'h1;
                        if (state_q.edge_count + 3'h1 ==
                            `REF_EDGES_TO_OUTPUT) begin
                            state_d.mode = ulpi_clk_pkg::CLK_PIN_OUTPUT;
                        end
                    end
                end
                ulpi_clk_pkg::CLK_PIN_OUTPUT: begin
                    // Each reference edge adds the half periods owed; the
                    // clock toggles at most once per cycle to pay them.
                    phase_sum = {1'b0, state_q.phase};
                    if (ref_rise) begin
                        phase_sum = phase_sum + {1'b0, step};
                    end
                    if (phase_sum >= {1'b0, `PHASE_UNIT}) begin
                        phase_sum        = phase_sum - {1'b0, `PHASE_UNIT};
                        state_d.ulpi_clk = !state_q.ulpi_clk;
                    end
                    if (phase_sum > {1'b0, `PHASE_LIMIT}) begin
                        phase_sum = {1'b0, `PHASE_LIMIT};
                    end
                    state_d.phase = phase_sum[7:0];
                end
                default: begin
                    state_d.mode = ulpi_clk_pkg::CLK_PIN_INPUT;
                end
            endcase
        end

        // ULPI outputs are registered once and released when powered down.
        state_d.drive.bus_oe  = operate;
        state_d.drive.dir     = operate && core_dir_i;
        state_d.drive.nxt     = operate && core_nxt_i;
        state_d.drive.data_oe = operate && core_data_oe_i;
        state_d.drive.data    = operate ? core_data_i : `DATA_RST;
        state_d.supply_en     = operate && bus_supply_req_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q            <= '0;
            state_q.mode       <= ulpi_clk_pkg::CLK_PIN_INPUT;
            state_q.edge_count <= `EDGE_COUNT_RST;
            state_q.phase      <= `PHASE_RST;
            state_q.drive.data <= `DATA_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign ulpi_clk_o     = state_q.ulpi_clk;
    assign ulpi_clk_oe_o  = (state_q.mode == ulpi_clk_pkg::CLK_PIN_OUTPUT)
                            && state_q.drive.bus_oe;
    assign ulpi_data_o    = state_q.drive.data;
    assign ulpi_data_oe_o = state_q.drive.data_oe;
    assign ulpi_dir_o     = state_q.drive.dir;
    assign ulpi_dir_oe_o  = state_q.drive.bus_oe;
    assign ulpi_nxt_o     = state_q.drive.nxt;
    assign ulpi_nxt_oe_o  = state_q.drive.bus_oe;
    assign ref_freq_high_o = state_q.freq_high;
    assign clk_out_mode_o  = (state_q.mode == ulpi_clk_pkg::CLK_PIN_OUTPUT);
    assign operating_o     = state_q.drive.bus_oe;
    assign bus_supply_enable_out_o = state_q.supply_en;

    a_freq_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ref_freq_high_o == $past(state_q.sync.fsel_s2))
        else $error("reference frequency select not followed");

    a_data_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        operate |=> ulpi_data_o == $past(core_data_i))
        else $error("ULPI data not registered from core");

    a_clk_default: assert property (@(posedge clk_i)
        $rose(rst_n_i) |-> !ulpi_clk_oe_o ##1 !ulpi_clk_oe_o)
        else $error("ULPI clock pin driven after reset");

    a_switch_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        operate && ref_rise && !clk_out_mode_o
        && state_q.edge_count == 3'h3 |=> clk_out_mode_o)
        else $error("clock pin did not switch on fourth edge");

    a_no_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(clk_out_mode_o) |-> $past(state_q.edge_count) == 3'h3)
        else $error("clock pin switched before four edges");

    a_cs_tristate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !state_q.sync.cs_s2 |=> !ulpi_clk_oe_o && !ulpi_data_oe_o
        && !ulpi_dir_oe_o && !ulpi_nxt_oe_o)
        else $error("ULPI outputs driven while deselected");

    a_supply_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_supply_enable_out_o |-> $past(bus_supply_req_i)
        && $past(operate))
        else $error("bus supply enabled without request");

    a_reset_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !state_q.sync.rst_n_s2 |=> !clk_out_mode_o && !operating_o
        && !bus_supply_enable_out_o)
        else $error("operation while reset pin low");

    a_mode_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_out_mode_o && operate |=> clk_out_mode_o)
        else $error("output mode left without power-down");

    a_clk_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_out_mode_o && operate && ref_rise
        |=> ##[0:1] $changed(ulpi_clk_o))
        else $error("ULPI clock not derived from reference edge");

    a_data_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !operate |=> ulpi_data_o == `DATA_RST && !ulpi_dir_o
        && !ulpi_nxt_o)
        else $error("ULPI lines not cleared while powered down");

    a_oe_operate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        operate |=> ulpi_dir_oe_o && ulpi_nxt_oe_o && operating_o)
        else $error("ULPI outputs released in normal operation");

    a_count_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !operate |=> state_q.edge_count == `EDGE_COUNT_RST
        && !clk_out_mode_o)
        else $error("edge count kept through power-down");

    a_input_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !clk_out_mode_o |-> !ulpi_clk_o && !ulpi_clk_oe_o)
        else $error("ULPI clock pin active in input mode");

    a_supply_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !bus_supply_req_i |=> !bus_supply_enable_out_o)
        else $error("bus supply on without request");

    // Owed half periods must be paid one per cycle, never held back.
    a_phase_pay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_out_mode_o && operate && state_q.phase >= `PHASE_UNIT
        |=> $changed(ulpi_clk_o))
        else $error("owed ULPI clock half period not paid");

endmodule
`default_nettype wire

/* tb/link_partner.sv */
// Far-side model that drives the reference clock pin in bursts.
`default_nettype none
module link_partner (
    input  wire logic run_i,
    output logic      ref_o,
    output int        edges_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pin rests grounded between bursts and runs at 80 ns inside them.
    initial begin
        ref_o = 1'b0;
        edges_o = 0;
        forever begin
            wait (run_i);
            #40 ref_o = 1'b1;
            edges_o++;
            #40 ref_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/ulpi_clock_mode_and_pin_control_tb.sv */
// Self-checking bench for the ULPI clock mode and pin control block.
`default_nettype none
module ulpi_clock_mode_and_pin_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rst_n = 0, fsel = 0, cs = 0, rpin = 0, req = 0;
    logic       run = 0, coe = 1, cdir = 0, cnxt = 0;
    logic [7:0] cd = 8'h00, ud;
    logic       rclk, uclk, uoe, doe, dir, dir_oe, nxt, nxt_oe, fhi, md, op;
    logic       sup;
    int         edges, base, f, step, tog, cyc = 0;
    int         mismatches = 0;
    int         comparisons = 0;
    int         w;
    int         exp_q[$];
    always #5 clk = ~clk;
    always @(uclk) tog++;
    link_partner link_u (.run_i(run), .ref_o(rclk), .edges_o(edges));
    ulpi_clock_mode_and_pin_control dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .reference_clock_in_i(rclk),
        .freq_select_i(fsel), .chip_select_i(cs),
        .active_low_reset_in_n_i(rpin), .bus_supply_req_i(req),
        .core_data_i(cd), .core_data_oe_i(coe), .core_dir_i(cdir),
        .core_nxt_i(cnxt), .ulpi_clk_o(uclk), .ulpi_clk_oe_o(uoe),
        .ulpi_data_o(ud), .ulpi_data_oe_o(doe), .ulpi_dir_o(dir),
        .ulpi_dir_oe_o(dir_oe), .ulpi_nxt_o(nxt), .ulpi_nxt_oe_o(nxt_oe),
        .ref_freq_high_o(fhi), .clk_out_mode_o(md), .operating_o(op),
        .bus_supply_enable_out_o(sup));
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Lets n more reference edges through, then grounds the pin again.
    task automatic burst(input int n);
        int t;
        t = edges + n;
        run = 1'b1;
        while (edges < t) @(negedge clk);
        run = 1'b0;
        wait_n(12);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h3583A70F));
        wait_n(12);
        rst_n = 1'b1;
        wait_n(2);
        chk("clk_oe", 8'h00, uoe);
        chk("oper", 8'h00, op);
        cs = 1'b1;
        rpin = 1'b1;
        wait_n(3);
        chk("oper", 8'h01, op);
        chk("dir_oe", 8'h01, dir_oe);
        base = edges;
        wait_n(50);
        chk("mode", 8'h00, md);
        for (int i = 0; i < 2; i++) begin
            fsel = i[0];
            burst(3);
            chk("mode", 8'(edges - base >= 4), md);
            burst(1);
            chk("mode", 8'(edges - base >= 4), md);
            chk("clk_oe", 8'h01, uoe);
            chk("freq", {7'h00, fsel}, fhi);
            f = fsel ? 26000 : 19200;
            step = (1920000 + f / 2) / f;
            tog = 0;
            burst(16);
            chk("toggles", 8'h01, 8'((tog - step) inside {[-3:3]}));
            cs = 1'b0;
            wait_n(4);
            chk("clk_oe", 8'h00, uoe);
            chk("mode", 8'h00, md);
            chk("data_oe", 8'h00, doe);
            chk("nxt_oe", 8'h00, nxt_oe);
            cs = 1'b1;
            wait_n(4);
            base = edges;
        end
        for (int i = 0; i < 8; i++) begin
            {cd, coe, cdir, cnxt, req} = 12'($urandom);
            exp_q.push_back(int'({cd, coe, cdir, cnxt, req}));
            @(negedge clk);
            w = exp_q.pop_front();
            chk("data", w[11:4], ud);
            chk("data_oe", {7'h00, w[3]}, doe);
            chk("dir_nxt", {6'h00, w[2:1]}, {6'h00, dir, nxt});
            chk("supply", {7'h00, w[0]}, sup);
        end
        req = 1'b1;
        rpin = 1'b0;
        wait_n(4);
        chk("oper", 8'h00, op);
        chk("supply", 8'h00, sup);
        rpin = 1'b1;
        wait_n(4);
        rst_n = 1'b0;
        wait_n(2);
        chk("oper", 8'h00, op);
        close_out();
    end
endmodule
`default_nettype wire
